// ### src/sqb_map.vh
// constants and register map of the sequential logic blocks
`ifndef SQB_MAP_VH
`define SQB_MAP_VH

`define SQB_ADDR_CTRL   8'h00
`define SQB_ADDR_HIGH   8'h04
`define SQB_ADDR_LOW    8'h08
`define SQB_ADDR_PULSES 8'h0C
`define SQB_ADDR_PAUSES 8'h10
`define SQB_ADDR_SEQS   8'h14
`define SQB_ADDR_STATUS 8'h18
`define SQB_ADDR_DONE   8'h1C

`define SQB_CTRL_INV_SET   0
`define SQB_CTRL_INV_RST   1
`define SQB_CTRL_INV_J     2
`define SQB_CTRL_INV_K     3
`define SQB_CTRL_INV_JKCLK 4
`define SQB_CTRL_STOP_LO   5
`define SQB_CTRL_STOP_HI   6
`define SQB_CTRL_W         7

`define SQB_STOP_NOW   2'h0
`define SQB_STOP_CYCLE 2'h1
`define SQB_STOP_SEQ   2'h2
`define SQB_STOP_ALL   2'h3

`define SQB_CTRL_RST   7'h00
`define SQB_DUR_RST    16'h0004
`define SQB_CNT_RST    16'h0000

`define SQB_CLK_KHZ    40000
`define SQB_LOGIC_MS   4

`endif

// ### src/sqb_logic.v
// sequential logic blocks: toggle, memory cell, edge flip-flop, generator
`default_nettype none
`include "sqb_map.vh"

module sqb_logic #(
	parameter LOGIC_MS    = `SQB_LOGIC_MS,
	parameter TICK_CYCLES = `SQB_LOGIC_MS * `SQB_CLK_KHZ
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        clkEn,
	input  wire [7:0]  addr,
	input  wire [31:0] wrData,
	input  wire        wrStb,
	input  wire        rdStb,
	output reg  [31:0] rdData,
	input  wire        togIn,
	input  wire        togReset,
	input  wire        cellSet,
	input  wire        cellReset,
	input  wire        jkSet,
	input  wire        jkClear,
	input  wire        jkClock,
	input  wire        genEnable,
	output reg         togQ,
	output reg         togQn,
	output reg         cellQ,
	output reg         cellQn,
	output reg         jkQ,
	output reg         jkQn,
	output reg         genClk,
	output reg         genReady
);

	localparam NIN = 8;
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_HIGH  = 2'h1;
	localparam [1:0] ST_LOW   = 2'h2;
	localparam [1:0] ST_PAUSE = 2'h3;
	localparam [17:0] STEP_MS = LOGIC_MS[17:0];

	// input bit order in the sampled vector
	localparam I_TOG  = 0;
	localparam I_TRST = 1;
	localparam I_SET  = 2;
	localparam I_RST  = 3;
	localparam I_J    = 4;
	localparam I_K    = 5;
	localparam I_CLK  = 6;
	localparam I_EN   = 7;

	reg  [31:0]          tickCnt;
	reg                  tick;
	reg  [NIN-1:0]       syncA;
	reg  [NIN-1:0]       syncB;
	reg  [NIN-1:0]       prevIn;
	reg  [`SQB_CTRL_W-1:0] ctrl;
	reg  [15:0]          highMs;
	reg  [15:0]          lowMs;
	reg  [15:0]          pulses;
	reg  [15:0]          pauses;
	reg  [15:0]          seqs;
	reg  [1:0]           state;
	reg  [17:0]          elapsed;
	reg  [15:0]          pulseNum;
	reg  [15:0]          pauseNum;
	reg  [15:0]          seqNum;
	reg                  stopPend;
	reg  [15:0]          doneCnt;

	wire [NIN-1:0] cur;
	wire [1:0]     stopMode;
	wire           endlessCycle;
	wire           endlessSeq;
	wire [17:0]    nextElapsed;
	wire [17:0]    periodMs;
	wire           highDone;
	wire           lowDone;
	wire           pauseDone;
	wire           lastPulse;
	wire           lastPause;
	wire           lastSeq;
	wire           jkClkEdge;
	wire           enRise;
	wire           enFall;
	wire           stopAfterSeq;

	function rising;
		input now;
		input prior;
		begin
			rising = now & ~prior;
		end
	endfunction

	function reachedMs;
		input [17:0] spent;
		input [17:0] target;
		begin
			reachedMs = (spent >= target);
		end
	endfunction

	// invert selected inputs before evaluation
	// inversion of the set, reset, J, K and flip-flop clock inputs
	assign cur = syncB ^ {1'b0,
		ctrl[`SQB_CTRL_INV_JKCLK], ctrl[`SQB_CTRL_INV_K],
		ctrl[`SQB_CTRL_INV_J], ctrl[`SQB_CTRL_INV_RST],
		ctrl[`SQB_CTRL_INV_SET], 2'b00};
	assign stopMode = ctrl[`SQB_CTRL_STOP_HI:`SQB_CTRL_STOP_LO];
	assign endlessCycle = (pulses == `SQB_CNT_RST);
	assign endlessSeq   = !endlessCycle && (seqs == `SQB_CNT_RST);

	// phase ends on whole logic cycles
	assign nextElapsed = elapsed + STEP_MS;
	assign periodMs    = {2'b00, highMs} + {2'b00, lowMs};
	assign highDone    = reachedMs(nextElapsed, {2'b00, highMs});
	assign lowDone     = reachedMs(nextElapsed, {2'b00, lowMs});
	assign pauseDone   = reachedMs(nextElapsed, periodMs);
	assign lastPulse = (pulseNum + 16'h0001 == pulses);
	assign lastPause = (pauseNum + 16'h0001 >= pauses);
	assign lastSeq   = !endlessSeq && (seqNum + 16'h0001 == seqs);
	assign jkClkEdge = rising(cur[I_CLK], prevIn[I_CLK]);
	assign enRise    = rising(cur[I_EN], prevIn[I_EN]);
	assign enFall    = rising(prevIn[I_EN], cur[I_EN]);

	assign stopAfterSeq = stopPend &&
		(stopMode == `SQB_STOP_SEQ || stopMode == `SQB_STOP_CYCLE ||
		(stopMode == `SQB_STOP_ALL && endlessSeq));

	// logic cycle timebase
	// one evaluation per logic cycle
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			tickCnt <= 32'h00000000;
			tick    <= 1'b0;
		end else if (clkEn) begin
			if (tickCnt == TICK_CYCLES - 1) begin
				tickCnt <= 32'h00000000;
				tick    <= 1'b1;
			end else begin
				tickCnt <= tickCnt + 32'h00000001;
				tick    <= 1'b0;
			end
		end
	end

	// pin synchroniser
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			syncA <= {NIN{1'b0}};
			syncB <= {NIN{1'b0}};
		end else if (clkEn) begin
			syncA <= {genEnable, jkClock, jkClear, jkSet,
				cellReset, cellSet, togReset, togIn};
			syncB <= syncA;
		end
	end

	// register writes
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl   <= `SQB_CTRL_RST;
			highMs <= `SQB_DUR_RST;
			lowMs  <= `SQB_DUR_RST;
			pulses <= `SQB_CNT_RST;
			pauses <= `SQB_CNT_RST;
			seqs   <= `SQB_CNT_RST;
		end else if (clkEn && wrStb) begin
			case (addr)
				`SQB_ADDR_CTRL: begin
					ctrl <= wrData[`SQB_CTRL_W-1:0];
				end
				// durations clamped to 4 ms minimum
				`SQB_ADDR_HIGH: begin
					highMs <= (wrData[15:0] < `SQB_DUR_RST) ?
						`SQB_DUR_RST : wrData[15:0];
				end
				`SQB_ADDR_LOW: begin
					lowMs <= (wrData[15:0] < `SQB_DUR_RST) ?
						`SQB_DUR_RST : wrData[15:0];
				end
				`SQB_ADDR_PULSES: begin
					pulses <= wrData[15:0];
				end
				`SQB_ADDR_PAUSES: begin
					pauses <= wrData[15:0];
				end
				`SQB_ADDR_SEQS: begin
					seqs <= wrData[15:0];
				end
				default: begin
					ctrl <= ctrl;
				end
			endcase
		end
	end

	// register reads, data in the following cycle
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rdData <= 32'h00000000;
		end else if (clkEn) begin
			if (rdStb) begin
				case (addr)
					`SQB_ADDR_CTRL:   rdData <= {25'h0, ctrl};
					`SQB_ADDR_HIGH:   rdData <= {16'h0, highMs};
					`SQB_ADDR_LOW:    rdData <= {16'h0, lowMs};
					`SQB_ADDR_PULSES: rdData <= {16'h0, pulses};
					`SQB_ADDR_PAUSES: rdData <= {16'h0, pauses};
					`SQB_ADDR_SEQS:   rdData <= {16'h0, seqs};
					`SQB_ADDR_STATUS: rdData <= {16'h0, seqNum[7:0],
						stopPend, state, genClk, jkQ, cellQ, togQ,
						tick};
					`SQB_ADDR_DONE:   rdData <= {16'h0, doneCnt};
					default:          rdData <= 32'h00000000;
				endcase
			end else begin
				rdData <= 32'h00000000;
			end
		end
	end

	// toggle, memory cell and edge flip-flop
	// outputs start low, complements high
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prevIn <= {NIN{1'b0}};
			togQ   <= 1'b0;
			togQn  <= 1'b1;
			cellQ  <= 1'b0;
			cellQn <= 1'b1;
			jkQ    <= 1'b0;
			jkQn   <= 1'b1;
		end else if (clkEn && tick) begin
			prevIn <= cur;
			if (cur[I_TRST]) begin
				togQ  <= 1'b0;
				togQn <= 1'b1;
			end else if (rising(cur[I_TOG], prevIn[I_TOG])) begin
				togQ  <= ~togQ;
				togQn <= togQ;
			end
			if (cur[I_RST]) begin
				cellQ  <= 1'b0;
				cellQn <= 1'b1;
			end else if (cur[I_SET]) begin
				cellQ  <= 1'b1;
				cellQn <= 1'b0;
			end
			if (jkClkEdge) begin
				case ({cur[I_J], cur[I_K]})
					2'b10: begin
						jkQ  <= 1'b1;
						jkQn <= 1'b0;
					end
					2'b01: begin
						jkQ  <= 1'b0;
						jkQn <= 1'b1;
					end
					2'b11: begin
						jkQ  <= ~jkQ;
						jkQn <= jkQ;
					end
					default: begin
						jkQ  <= jkQ;
						jkQn <= jkQn;
					end
				endcase
			end
		end
	end

	// pulse generator
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state    <= ST_IDLE;
			elapsed  <= 18'h00000;
			pulseNum <= 16'h0000;
			pauseNum <= 16'h0000;
			seqNum   <= 16'h0000;
			stopPend <= 1'b0;
			genClk   <= 1'b0;
			genReady <= 1'b0;
			doneCnt  <= 16'h0000;
		end else if (clkEn && tick) begin
			genReady <= 1'b0;
			if (state != ST_IDLE && enFall) begin
				stopPend <= 1'b1;
			end
			case (state)
				ST_IDLE: begin
					genClk   <= 1'b0;
					stopPend <= 1'b0;
					if (enRise) begin
						state    <= ST_HIGH;
						genClk   <= 1'b1;
						elapsed  <= 18'h00000;
						pulseNum <= 16'h0000;
						pauseNum <= 16'h0000;
						seqNum   <= 16'h0000;
					end
				end
				ST_HIGH: begin
					elapsed <= nextElapsed;
					if (highDone) begin
						state   <= ST_LOW;
						genClk  <= 1'b0;
						elapsed <= 18'h00000;
					end
				end
				ST_LOW: begin
					elapsed <= nextElapsed;
					if (lowDone) begin
						elapsed  <= 18'h00000;
						pulseNum <= pulseNum + 16'h0001;
						if ((stopPend || enFall) &&
							(stopMode == `SQB_STOP_CYCLE ||
							endlessCycle)) begin
							state    <= ST_IDLE;
							genReady <= 1'b1;
						end else if (endlessCycle) begin
							state  <= ST_HIGH;
							genClk <= 1'b1;
						end else if (!lastPulse) begin
							state  <= ST_HIGH;
							genClk <= 1'b1;
						end else if (pauses != `SQB_CNT_RST) begin
							state    <= ST_PAUSE;
							pauseNum <= 16'h0000;
						end else if (lastSeq || stopAfterSeq) begin
							state    <= ST_IDLE;
							genReady <= 1'b1;
						end else begin
							state    <= ST_HIGH;
							genClk   <= 1'b1;
							pulseNum <= 16'h0000;
							seqNum   <= seqNum + 16'h0001;
						end
					end
				end
				ST_PAUSE: begin
					elapsed <= nextElapsed;
					if (pauseDone) begin
						elapsed  <= 18'h00000;
						pauseNum <= pauseNum + 16'h0001;
						if (!lastPause) begin
							state <= ST_PAUSE;
						end else if (lastSeq || stopAfterSeq) begin
							state    <= ST_IDLE;
							genReady <= 1'b1;
						end else begin
							state    <= ST_HIGH;
							genClk   <= 1'b1;
							pulseNum <= 16'h0000;
							seqNum   <= seqNum + 16'h0001;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
			if (state != ST_IDLE && !cur[I_EN] &&
				stopMode == `SQB_STOP_NOW) begin
				state    <= ST_IDLE;
				genClk   <= 1'b0;
				genReady <= 1'b1;
			end
			// tally of finished generations
			if (genReady) begin
				doneCnt <= doneCnt + 16'h0001;
			end
		end
	end

endmodule // sqb_logic
`default_nettype wire

// ### sim/sqb_logic_monitor.sv
// assertion checker bound to the sequential logic blocks
`default_nettype none
module sqb_logic_monitor #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic togReset,
	input wire logic jkClock,
	input wire logic togQ,
	input wire logic togQn,
	input wire logic cellQ,
	input wire logic cellQn,
	input wire logic jkQ,
	input wire logic jkQn,
	input wire logic genClk,
	input wire logic genReady
);
	int rdyCnt;
	int clkAge;
	int chgAge;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ready length and pin-change ages
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdyCnt <= 0;
			clkAge <= 99;
			chgAge <= 99;
		end else begin
			rdyCnt <= genReady ? rdyCnt + 1 : 0;
			clkAge <= $changed(jkClock) ? 0 : clkAge + 1;
			chgAge <= $changed(togQ) ? 0 : chgAge + 1;
		end
	end
	AST_TOG_PAIR: assert property (togQn == !togQ)
		else $error("toggle outputs not complementary");
	AST_TOG_RESET: assert property (togReset[*8] |-> !togQ && togQn)
		else $error("toggle reset did not clear state");
	AST_CELL_PAIR: assert property (cellQn == !cellQ)
		else $error("cell outputs not complementary");
	AST_JK_PAIR: assert property (jkQn == !jkQ)
		else $error("flip-flop outputs not complementary");
	AST_JK_EDGE: assert property (
		$changed(jkQ) |-> clkAge <= TICK_CYCLES + 4)
		else $error("flip-flop changed without clock pin activity");
	AST_TICK_GAP: assert property (
		$changed(togQ) |-> chgAge >= TICK_CYCLES - 1)
		else $error("toggle changed twice within one logic cycle");
	AST_RDY_MAX: assert property (genReady |-> rdyCnt < TICK_CYCLES)
		else $error("ready longer than one logic cycle");
	AST_RDY_LEN: assert property (
		$fell(genReady) |-> rdyCnt == TICK_CYCLES)
		else $error("ready shorter than one logic cycle");
	AST_RDY_IDLE: assert property (genReady |-> !genClk)
		else $error("generator clock high at end of generation");
	AST_RST_STATE: assert property (
		$fell(reset) |-> !togQ && !cellQ && !jkQ && !genClk)
		else $error("outputs not idle after reset");
endmodule // sqb_logic_monitor

bind sqb_logic sqb_logic_monitor #(.TICK_CYCLES(TICK_CYCLES))
	sqb_logic_monitor_inst (.clk(clk), .reset(reset), .togReset(togReset),
	.jkClock(jkClock), .togQ(togQ), .togQn(togQn), .cellQ(cellQ),
	.cellQn(cellQn), .jkQ(jkQ), .jkQn(jkQn), .genClk(genClk),
	.genReady(genReady));
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the sequential logic blocks
`default_nettype none
`include "sqb_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 4;
	logic        clk = 0, reset = 1, clkEn = 1, wrStb = 0, rdStb = 0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wrData = 32'h0, rdData;
	logic        togIn = 0, togReset = 0, cellSet = 0, cellReset = 0;
	logic        jkSet = 0, jkClear = 0, jkClock = 0, genEnable = 0;
	logic        togQ, togQn, cellQ, cellQn, jkQ, jkQn, genClk, genReady;
	logic [4:0]  ci = 5'h00;
	logic        cq = 0, jq = 0;
	int          fail_count = 0, total_checks = 0;
	always #12.5 clk = ~clk;
	sqb_logic #(.TICK_CYCLES(TICK)) sqb_logic_inst (.clk(clk),
		.reset(reset), .clkEn(clkEn), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .togIn(togIn),
		.togReset(togReset), .cellSet(cellSet), .cellReset(cellReset),
		.jkSet(jkSet), .jkClear(jkClear), .jkClock(jkClock),
		.genEnable(genEnable), .togQ(togQ), .togQn(togQn), .cellQ(cellQ),
		.cellQn(cellQn), .jkQ(jkQ), .jkQn(jkQn), .genClk(genClk),
		.genReady(genReady));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1;
		wait_n(1);
		wrStb <= 0;
		wait_n(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rdStb <= 1;
		wait_n(1);
		rdStb <= 0;
		wait_n(1);
		check(rdData, e);
	endtask
	function automatic logic cell_next(input logic s, r, q);
		return r ? 1'b0 : (s ? 1'b1 : q);
	endfunction
	function automatic logic jk_next(input logic j, k, q);
		return (j & k) ? ~q : ((j | k) ? j : q);
	endfunction
	// runs one generation, counts pulses and timings
	task automatic gen(input logic [15:0] hi, p, ps, s, input logic [1:0] m,
		input int dropAt, output int rises, lat, hiLen);
		int i, run;
		wr(`SQB_ADDR_CTRL, {25'h0, m, ci});
		wr(`SQB_ADDR_HIGH, {16'h0, hi});
		wr(`SQB_ADDR_LOW, 32'h4);
		wr(`SQB_ADDR_PULSES, {16'h0, p});
		wr(`SQB_ADDR_PAUSES, {16'h0, ps});
		wr(`SQB_ADDR_SEQS, {16'h0, s});
		genEnable <= 1;
		rises = 0;
		lat = 0;
		hiLen = 0;
		run = 0;
		for (i = 0; i < 2000 && genReady !== 1'b1; i++) begin
			@(posedge clk);
			if (genClk === 1'b1) begin
				run++;
				if (run == 1)
					rises++;
			end else begin
				if (run > 0 && hiLen == 0)
					hiLen = run;
				run = 0;
			end
			if (rises == dropAt && genEnable)
				genEnable <= 0;
			if (!genEnable)
				lat++;
		end
		if (genReady !== 1'b1) begin
			fail_count++;
			test_done();
		end
		genEnable <= 0;
		wait_n(12);
	endtask
	initial begin
		int n, rs, lt, hl;
		logic [15:0] hi;
		logic [31:0] r4;
		r4 = $urandom(9764);
		wait_n(3);
		reset <= 0;
		wait_n(1);
		check({togQ, togQn, cellQ, cellQn, jkQ, jkQn, genClk}, 7'h2A);
		rd(`SQB_ADDR_HIGH, 32'h4);
		wr(`SQB_ADDR_HIGH, 32'h1);
		rd(`SQB_ADDR_HIGH, 32'h4);
		wr(`SQB_ADDR_SEQS, 32'hFFFF);
		rd(`SQB_ADDR_SEQS, 32'hFFFF);
		rd(8'h20, 32'h0);
		n = $urandom_range(5, 1);
		repeat (n) begin
			togIn <= 1;
			wait_n(12);
			togIn <= 0;
			wait_n(12);
		end
		check({togQ, togQn}, {n[0], ~n[0]});
		clkEn <= 0;
		togIn <= 1;
		wait_n(12);
		togIn <= 0;
		check({togQ, togQn}, {n[0], ~n[0]});
		clkEn <= 1;
		wait_n(12);
		check({togQ, togQn}, {n[0], ~n[0]});
		togReset <= 1;
		togIn <= 1;
		wait_n(12);
		togIn <= 0;
		wait_n(12);
		check({togQ, togQn}, 2'b01);
		togReset <= 0;
		repeat (12) begin
			r4 = $urandom;
			ci[1:0] = r4[1:0];
			wr(`SQB_ADDR_CTRL, {27'h0, ci});
			wait_n(12);
			cq = cell_next(cellSet ^ ci[0], cellReset ^ ci[1], cq);
			cellSet <= r4[2];
			cellReset <= r4[3];
			wait_n(12);
			cq = cell_next(r4[2] ^ ci[0], r4[3] ^ ci[1], cq);
			check({cellQ, cellQn}, {cq, ~cq});
		end
		repeat (12) begin
			r4 = $urandom;
			jkSet <= ci[2];
			jkClear <= ci[3];
			jkClock <= ~ci[4];
			wait_n(12);
			ci[4:2] = r4[4:2];
			wr(`SQB_ADDR_CTRL, {27'h0, ci});
			wait_n(12);
			jkClock <= ci[4];
			jkSet <= r4[0] ^ ci[2];
			jkClear <= r4[1] ^ ci[3];
			wait_n(12);
			check(jkQ, jq);
			jkClock <= ~ci[4];
			wait_n(12);
			jq = jk_next(r4[0], r4[1], jq);
			check({jkQ, jkQn}, {jq, ~jq});
			jkClock <= ci[4];
			wait_n(12);
		end
		hi = 16'($urandom_range(16, 5));
		gen(hi, 16'h2, 16'h1, 16'h2, 2'h3, -1, rs, lt, hl);
		check(rs, 4);
		check(hl, ((hi + 3) / 4) * TICK);
		check(genClk, 1'b0);
		gen(16'hC, 16'h0, 16'h3, 16'h2, 2'h0, 20, rs, lt, hl);
		check(rs, 20);
		gen(16'hC, 16'h1, 16'h1, 16'h0, 2'h0, 20, rs, lt, hl);
		check(rs, 20);
		for (int m = 0; m < 4; m++) begin
			gen(16'hC, 16'h1, 16'h0, 16'h3, m[1:0], 1, rs, lt, hl);
			check(rs, m == 3 ? 3 : 1);
			if (m == 0)
				check(lt <= 10, 1);
		end
		rd(`SQB_ADDR_DONE, 32'h7);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
